// File: core/crod_defines.vh
`ifndef CROD_DEFINES_VH
`define CROD_DEFINES_VH
// Register byte addresses (one aligned 32-bit word each)
`define CROD_ADDR_OPTION 4'h0
`define CROD_ADDR_PROG 4'h4
`define CROD_ADDR_STATUS 4'h8
`define CROD_ADDR_PROTECT 4'hC
// Option byte fields
`define CROD_PKG_BIT 7
`define CROD_RESET_CYCLE_SELECT_BIT 6
`define CROD_TYPE_HI 5
`define CROD_TYPE_LO 4
`define CROD_RANGE_HI 3
`define CROD_RANGE_LO 1
`define CROD_PLLOFF_BIT 0
// Erased option byte value
`define CROD_OPT_ERASED 8'hFF
// Clock source type codes
`define CROD_SRC_RESONATOR 2'h0
`define CROD_SRC_RESERVED 2'h1
`define CROD_SRC_RC 2'h2
`define CROD_SRC_EXTERNAL 2'h3
// Range codes
`define CROD_RANGE_LP 3'h0
`define CROD_RANGE_MP 3'h1
`define CROD_RANGE_MS 3'h2
`define CROD_RANGE_HS 3'h3
// Reset phase lengths in CPU cycles
`define CROD_RST_LONG 13'h1000
`define CROD_RST_SHORT 13'h0100
// Port pad count and pad count bonded in small package on the last port
`define CROD_PADS 8
`define CROD_PAD_MASK_SMALL 8'h0F
`define CROD_PAD_MASK_ALL 8'hFF
// Program mode key written to the control register
`define CROD_PROG_KEY 8'hA5
`endif

// File: core/crod_stab_counter.v
`timescale 1ns/1ps
`default_nettype none
`include "crod_defines.vh"
module crod_stab_counter (
  // Clock and reset
  input wire i_clock,
  input wire i_nrst,
  // Control
  input wire i_start,
  input wire [12:0] i_length,
  // Status
  output reg o_busy,
  output reg [12:0] o_count
);
  ////////////////////////////////////////////////////////////////
  // Counts down the loaded length, busy while nonzero
  always @(posedge i_clock) begin
    if (!i_nrst) begin
      o_count <= 13'h0000;
      o_busy <= 1'b0;
    end else if (i_start) begin
      o_count <= i_length;
      o_busy <= 1'b1;
    end else if (o_count > 13'h0001) begin
      o_count <= o_count - 13'h0001;
    end else begin
      o_count <= 13'h0000;
      o_busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: core/crod_top.v
// Functional notes
// - Bit 7 set selects large package
// - Unbonded pads reset to input pull-up
// - Bit 6: 0 gives 4096, 1 gives 256
// - Bits 5:4 select main clock source
// - Resonator: range sets drive current
// - Other sources: range sets frequency band
// - Bit 0 low enables clock doubler
// - Protection polarity differs per variant
// - Option byte reachable only in programming
// - Reprogrammable: protect bit 0 enables protection
//
// Decided for this implementation: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "crod_defines.vh"
module crod_top (
  // Clock and reset
  input wire i_clock,
  input wire i_nrst,
  // Variant strap: high for factory coded part
  input wire i_rom_variant,
  // Avalon-MM slave
  input wire [3:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  output reg [1:0] o_avs_response,
  // Decoded settings
  output reg o_large_package,
  output reg [7:0] o_pad_pullup_mask,
  output reg [1:0] o_clock_source_type,
  output reg [2:0] o_oscillator_range_field,
  output reg [2:0] o_resonator_drive,
  output reg [2:0] o_frequency_band,
  output reg o_doubler_enable,
  output reg o_readout_protect,
  output reg [12:0] o_reset_cycles,
  output reg o_reset_active
);
  ////////////////////////////////////////////////////////////////
  // State
  reg [7:0] option_reg;
  reg [7:0] option_next;
  reg prog_mode_reg;
  reg prog_mode_next;
  reg protect_bit_reg;
  reg protect_bit_next;
  reg [7:0] latched_reg;
  reg ack_reg;
  reg [31:0] rdata_next;
  reg [1:0] resp_next;
  reg load_reg;
  wire stab_busy;
  wire [12:0] stab_count;
  wire access;
  wire [12:0] rst_len;
  wire [7:0] image;
  wire [7:0] small_unbonded;
  reg [2:0] variant_sync_reg;
  reg variant_reg;
  integer i;

  // One wait cycle per access: waitrequest drops in the cycle after request
  assign access = (i_avs_read | i_avs_write) & ~ack_reg;
  // Image seen by the counter; stored copy on the load cycle, else the latch
  assign image = load_reg ? option_reg : latched_reg;
  assign rst_len = image[`CROD_RESET_CYCLE_SELECT_BIT] ? `CROD_RST_SHORT : `CROD_RST_LONG;
  // Pads with no pin in the small package
  assign small_unbonded = ~`CROD_PAD_MASK_SMALL;

  ////////////////////////////////////////////////////////////////
  // Variant strap comes from a pin: three flops, accept when last two agree
  always @(posedge i_clock) begin
    if (!i_nrst) begin
      variant_sync_reg <= 3'h0;
      variant_reg <= 1'b0;
    end else begin
      variant_sync_reg <= {variant_sync_reg[1:0], i_rom_variant};
      if (variant_sync_reg[1] == variant_sync_reg[2]) begin
        variant_reg <= variant_sync_reg[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Register write decode
  always @* begin
    option_next = option_reg;
    prog_mode_next = prog_mode_reg;
    protect_bit_next = protect_bit_reg;
    // Write commits on the edge where waitrequest is seen low
    if (ack_reg && i_avs_write && i_avs_byteenable[0]) begin
      case (i_avs_address)
        `CROD_ADDR_OPTION: begin
          if (prog_mode_reg) begin
            option_next = i_avs_writedata[7:0];
          end
        end
        `CROD_ADDR_PROG: begin
          prog_mode_next = (i_avs_writedata[7:0] == `CROD_PROG_KEY);
        end
        `CROD_ADDR_PROTECT: begin
          if (prog_mode_reg) begin
            protect_bit_next = i_avs_writedata[0];
          end
        end
        default: begin
          prog_mode_next = prog_mode_reg;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read mux; option bytes hidden outside programming mode
  always @* begin
    rdata_next = 32'h00000000;
    resp_next = 2'h0;
    case (i_avs_address)
      `CROD_ADDR_OPTION: begin
        if (prog_mode_reg) begin
          rdata_next = {24'h000000, option_reg};
        end else begin
          resp_next = 2'h2;
        end
      end
      `CROD_ADDR_PROG: rdata_next = {31'h00000000, prog_mode_reg};
      `CROD_ADDR_STATUS: rdata_next = {18'h00000, stab_busy, stab_count};
      `CROD_ADDR_PROTECT: begin
        if (prog_mode_reg) begin
          rdata_next = {31'h00000000, protect_bit_reg};
        end else begin
          resp_next = 2'h2;
        end
      end
      default: resp_next = 2'h2;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Bus handshake and programming mode flag (cleared by functional reset)
  always @(posedge i_clock) begin
    if (!i_nrst) begin
      ack_reg <= 1'b0;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h00000000;
      o_avs_response <= 2'h0;
      prog_mode_reg <= 1'b0;
    end else begin
      ack_reg <= access;
      o_avs_waitrequest <= ~access;
      o_avs_readdata <= (access && i_avs_read) ? rdata_next : 32'h00000000;
      o_avs_response <= access ? resp_next : 2'h0;
      prog_mode_reg <= prog_mode_next;
    end
  end

  // Stored image models the erased non-volatile content at power-up
  initial begin
    option_reg = `CROD_OPT_ERASED;
    protect_bit_reg = 1'b1;
  end
  always @(posedge i_clock) begin
    option_reg <= option_next;
    protect_bit_reg <= protect_bit_next;
  end

  ////////////////////////////////////////////////////////////////
  // capture option image one cycle after reset release
  always @(posedge i_clock) begin
    if (!i_nrst) begin
      load_reg <= 1'b1;
      latched_reg <= `CROD_OPT_ERASED;
    end else begin
      load_reg <= 1'b0;
      if (load_reg) begin
        latched_reg <= option_reg;
      end
    end
  end

  // Reset phase stabilisation counter
  crod_stab_counter u_stab (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_start(load_reg),
    .i_length(rst_len),
    .o_busy(stab_busy),
    .o_count(stab_count)
  );

  ////////////////////////////////////////////////////////////////
  // Decoded outputs, all registered
  always @(posedge i_clock) begin
    if (!i_nrst) begin
      o_large_package <= 1'b1;
      o_pad_pullup_mask <= `CROD_PAD_MASK_ALL;
      o_clock_source_type <= `CROD_SRC_RC;
      o_oscillator_range_field <= `CROD_RANGE_LP;
      o_resonator_drive <= 3'h0;
      o_frequency_band <= 3'h0;
      o_doubler_enable <= 1'b0;
      o_readout_protect <= 1'b0;
      o_reset_cycles <= `CROD_RST_LONG;
      o_reset_active <= 1'b1;
    end else begin
      o_large_package <= latched_reg[`CROD_PKG_BIT];
      // unbonded pads held as pulled-up inputs
      for (i = 0; i < `CROD_PADS; i = i + 1) begin
        o_pad_pullup_mask[i] <= latched_reg[`CROD_PKG_BIT] ? 1'b0 : small_unbonded[i];
      end
      o_clock_source_type <= latched_reg[`CROD_TYPE_HI:`CROD_TYPE_LO];
      o_oscillator_range_field <= latched_reg[`CROD_RANGE_HI:`CROD_RANGE_LO];
      // resonator drive current only for resonator type
      o_resonator_drive <= (latched_reg[`CROD_TYPE_HI:`CROD_TYPE_LO] == `CROD_SRC_RESONATOR)
        ? latched_reg[`CROD_RANGE_HI:`CROD_RANGE_LO] : 3'h0;
      o_frequency_band <= (latched_reg[`CROD_TYPE_HI:`CROD_TYPE_LO] != `CROD_SRC_RESONATOR)
        ? latched_reg[`CROD_RANGE_HI:`CROD_RANGE_LO] : 3'h0;
      o_doubler_enable <= ~latched_reg[`CROD_PLLOFF_BIT];
      o_readout_protect <= variant_reg ? protect_bit_reg : ~protect_bit_reg;
      o_reset_cycles <= rst_len;
      o_reset_active <= load_reg | stab_busy;
    end
  end
endmodule
`default_nettype wire

// File: bench/crod_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module crod_monitor (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // Bus
  input wire logic i_avs_read,
  input wire logic [3:0] i_avs_address,
  input wire logic o_avs_waitrequest,
  input wire logic [1:0] o_avs_response,
  // Settings
  input wire logic o_large_package,
  input wire logic [7:0] o_pad_pullup_mask,
  input wire logic [1:0] o_clock_source_type,
  input wire logic [2:0] o_oscillator_range_field,
  input wire logic [2:0] o_resonator_drive,
  input wire logic [2:0] o_frequency_band,
  input wire logic [12:0] o_reset_cycles
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  logic [1:0] up_reg;
  wire settled = up_reg == 2'h3;
  // Decode settles two edges after release
  always_ff @(posedge i_clock) begin
    if (!i_nrst) up_reg <= 2'h0;
    else if (!settled) up_reg <= up_reg + 2'h1;
  end
  ////////////////////////////////////////
  property p_ack; $rose(i_avs_read) |=> !o_avs_waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("late answer");
  property p_one; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("long answer");
  property p_unmap; i_avs_read && !o_avs_waitrequest && i_avs_address == 4'h2
    |-> o_avs_response == 2'h2; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped ok");
  property p_pkg; settled |-> o_pad_pullup_mask == (o_large_package ? 8'h00 : 8'hF0);
  endproperty
  a_pkg: assert property (p_pkg) else $error("pad mask");
  property p_cyc; settled |-> o_reset_cycles inside {13'h1000, 13'h0100}; endproperty
  a_cyc: assert property (p_cyc) else $error("reset length");
  property p_drv; settled && o_clock_source_type == 2'h0
    |-> o_resonator_drive == o_oscillator_range_field && o_frequency_band == 3'h0; endproperty
  a_drv: assert property (p_drv) else $error("drive");
  property p_band; settled && o_clock_source_type != 2'h0
    |-> o_frequency_band == o_oscillator_range_field && o_resonator_drive == 3'h0; endproperty
  a_band: assert property (p_band) else $error("band");
  property p_hold; settled |-> $stable({o_reset_cycles, o_clock_source_type}); endproperty
  a_hold: assert property (p_hold) else $error("not held");
  c_res: cover property (settled && o_clock_source_type == 2'h0);
  c_short: cover property (settled && o_reset_cycles == 13'h0100);
  c_rd: cover property ($rose(i_avs_read));
endmodule
bind crod_top crod_monitor u_mon (.*);
`default_nettype wire

// File: bench/crod_prog_tool.sv
`timescale 1ns/1ps
`default_nettype none
module crod_prog_tool (
  // Clock and answer
  input wire logic i_clock,
  input wire logic i_wait,
  input wire logic [31:0] i_rdata,
  input wire logic [1:0] i_resp,
  // Request
  output logic [3:0] o_addr = 4'h0,
  output logic o_rd = 1'b0,
  output logic o_wr = 1'b0,
  output logic [31:0] o_wdata = 32'h0
);
  // Tool only writes supported combinations
  function automatic logic [7:0] legal(input logic [7:0] b);
    logic [7:0] v;
    v = b;
    if (v[5:4] == 2'h0) v[6] = 1'b0;
    if (v[5:4] != 2'h0 || v[3:1] != 3'h1) v[0] = 1'b1;
    return v;
  endfunction
  ////////////////////////////////////////
  // tool never touches unbonded pad setup
  // Request held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [31:0] q, output logic [1:0] r);
    @(posedge i_clock);
    o_addr <= a;
    o_rd <= !w;
    o_wr <= w;
    o_wdata <= {24'h0, d};
    do @(posedge i_clock); while (i_wait !== 1'b0);
    q = i_rdata;
    r = i_resp;
    o_rd <= 1'b0;
    o_wr <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic i_clock, i_nrst = 1'b0, i_rom_variant = 1'b0;
  logic [3:0] i_avs_address, i_avs_byteenable = 4'h1;
  logic i_avs_read, i_avs_write, o_avs_waitrequest, o_large_package, o_doubler_enable;
  logic [31:0] i_avs_writedata, o_avs_readdata, q;
  logic [1:0] o_avs_response, o_clock_source_type, r;
  logic [2:0] o_oscillator_range_field, o_resonator_drive, o_frequency_band;
  logic [7:0] o_pad_pullup_mask, opt, prev;
  logic o_readout_protect, o_reset_active;
  logic [12:0] o_reset_cycles;
  int err_total = 0, n_compared = 0, ticks = 0, n, e;
  crod_top dut (.*);
  crod_prog_tool tool (.i_clock(i_clock), .i_wait(o_avs_waitrequest),
    .i_rdata(o_avs_readdata), .i_resp(o_avs_response), .o_addr(i_avs_address),
    .o_rd(i_avs_read), .o_wr(i_avs_write), .o_wdata(i_avs_writedata));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      err_total++;
      $display("CHECK FAILED %0t got %0h expected %0h", $time, g, x);
    end
  endtask
  task automatic out_chk(input logic [7:0] o, input logic p);
    chk(o_large_package, o[7]);
    chk(o_pad_pullup_mask, o[7] ? 8'h00 : 8'hF0);
    chk(o_reset_cycles, o[6] ? 13'h0100 : 13'h1000);
    chk(o_clock_source_type, o[5:4]);
    chk(o_oscillator_range_field, o[3:1]);
    chk(o_resonator_drive, o[5:4] == 2'h0 ? o[3:1] : 3'h0);
    chk(o_frequency_band, o[5:4] != 2'h0 ? o[3:1] : 3'h0);
    chk(o_doubler_enable, !o[0]);
    chk(o_readout_protect, i_rom_variant ? p : !p);
  endtask
  task report_and_stop;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Clock and hang guard
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    ticks++;
    if (ticks == 30000) begin
      err_total++;
      report_and_stop;
    end
  end
  // One pass per clock source code
  initial begin
    repeat (8) @(posedge i_clock);
    i_nrst <= 1'b1;
    tool.acc(1'b0, 4'h0, 8'h00, q, r);
    chk({q[7:0], r}, {8'h00, 2'h2});
    tool.acc(1'b0, 4'h2, 8'h00, q, r);
    chk(r, 2'h2);
    for (int i = 0; i < 4; i++) begin
      opt = tool.legal({i[0], i[1], i[1:0], 1'b0, i[1:0] ^ 2'h1, 1'b0});
      tool.acc(1'b1, 4'h4, 8'hA5, q, r);
      tool.acc(1'b1, 4'h0, opt, q, r);
      tool.acc(1'b1, 4'hC, {7'h0, i[0]}, q, r);
      tool.acc(1'b0, 4'h0, 8'h00, q, r);
      chk(q, {24'h0, opt});
      if (i > 0) out_chk(prev, i[0]);
      prev = opt;
      i_rom_variant <= i[1];
      i_nrst <= 1'b0;
      repeat (2) @(posedge i_clock);
      i_nrst <= 1'b1;
      repeat (2) @(posedge i_clock);
      n = 2;
      while (o_reset_active === 1'b1 && n < 5000) begin
        @(posedge i_clock);
        n++;
      end
      e = opt[6] ? 256 : 4096;
      chk(n >= e && n <= e + 4, 1'b1);
      out_chk(opt, i[0]);
      tool.acc(1'b0, 4'h8, 8'h00, q, r);
      chk({q, r}, 34'h0);
    end
    report_and_stop;
  end
endmodule
`default_nettype wire
